// [pesd_consts.vh]
// constants for the performance event qualification block
// How it works
// - CBH/08H counts retired loads starting new line fetch.
// - one count per line fetched from memory.
// - only cacheable loads; software prefetches excluded.
// - blocked loads may go uncounted.
// - precise sample holds next instruction address.
// - CBH/10H counts translation misses, not faulting loads.
// - CCH/01H first packed-int after float instruction.
// - CCH/02H first float after packed-int instruction.
// - CDH/00H counts state-clear assists that alter state.
// - CEH/00H counts retired packed-int multimedia instructions.
// - CFH/00H counts retired saturating packed instructions.
// - D2H/01H counts each reorder read-port stall cycle.
// - retried stalled cycle is counted again.
`ifndef PESD_CONSTS_VH
`define PESD_CONSTS_VH
`define PESD_EV_MEM_LOAD   8'hcb
`define PESD_EV_TRANS      8'hcc
`define PESD_EV_ASSIST     8'hcd
`define PESD_EV_PINT_RET   8'hce
`define PESD_EV_SAT_RET    8'hcf
`define PESD_EV_RAT_STALL  8'hd2
`define PESD_UM_L2_LINE    8'h08
`define PESD_UM_XLATE      8'h10
`define PESD_UM_TO_PINT    8'h01
`define PESD_UM_TO_FLOAT   8'h02
`define PESD_UM_NONE       8'h00
`define PESD_UM_ROB_PORT   8'h01
`define PESD_ADDR_RESET    32'h0000_0000
`endif

// [pesd_top.v]
// event qualification logic feeding one performance counter
`timescale 1ns/100ps
`default_nettype none
`include "pesd_consts.vh"

module pesd_top #(
  parameter ADDR_W = 32
) (
  // clock and reset
  input  wire              CLK_IN,
  input  wire              RESETN_IN,
  // event selection
  input  wire [7:0]        EVENT_SEL_IN,
  input  wire [7:0]        UNIT_MASK_IN,
  // retired load reports
  input  wire              LOAD_RETIRE_IN,
  input  wire              LOAD_CACHEABLE_IN,
  input  wire              LOAD_SW_PREFETCH_IN,
  input  wire              LOAD_BLOCKED_IN,
  input  wire              LOAD_FAULT_IN,
  input  wire              LOAD_L2_MISS_IN,
  input  wire              LOAD_LINE_IN_FLIGHT_IN,
  input  wire              LOAD_XLATE_MISS_IN,
  input  wire [ADDR_W-1:0] NEXT_INSTR_ADDR_IN,
  // instruction class reports
  input  wire              FLOAT_INSTR_IN,
  input  wire              PINT_INSTR_IN,
  input  wire              STATE_CLEAR_EXEC_IN,
  input  wire              STATE_CLEAR_ALTERS_IN,
  input  wire              PINT_RETIRE_IN,
  input  wire              SAT_RETIRE_IN,
  // pipeline stall report
  input  wire              ROB_PORT_STALL_IN,
  // counter side
  output reg               COUNT_INC_OUT,
  output reg               SAMPLE_VALID_OUT,
  output reg  [ADDR_W-1:0] SAMPLE_ADDR_OUT
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rst_meta_q;
  reg rst_sync_q;
  always @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  wire rst_n = rst_sync_q;

  // ----------------------------------------
  // load qualification
  // ----------------------------------------
  // blocked loads are simply dropped from the line-fetch event; under-counting is allowed here
  wire load_ok = LOAD_RETIRE_IN & LOAD_CACHEABLE_IN & ~LOAD_SW_PREFETCH_IN;
  // a load hitting a line already being fetched adds nothing
  wire retired_load_l2_line_fetch = load_ok & LOAD_L2_MISS_IN & ~LOAD_LINE_IN_FLIGHT_IN
                                    & ~LOAD_BLOCKED_IN;
  wire retired_load_xlate_miss = load_ok & LOAD_XLATE_MISS_IN & ~LOAD_FAULT_IN;

  // ----------------------------------------
  // multimedia state transitions
  // ----------------------------------------
  // last class seen: 1 = packed-int, 0 = float
  reg pint_mode_q;
  reg pint_mode_d;
  always @* begin
    pint_mode_d = pint_mode_q;
    if (PINT_INSTR_IN)
      pint_mode_d = 1'b1;
    else if (FLOAT_INSTR_IN)
      pint_mode_d = 1'b0;
  end
  always @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n)
      pint_mode_q <= 1'b0;
    else
      pint_mode_q <= pint_mode_d;
  end
  wire float_to_packed_int_switch = PINT_INSTR_IN & ~pint_mode_q;
  wire packed_int_to_float_switch = FLOAT_INSTR_IN & ~PINT_INSTR_IN & pint_mode_q;

  wire multimedia_assist = STATE_CLEAR_EXEC_IN & STATE_CLEAR_ALTERS_IN;
  wire packed_int_retired = PINT_RETIRE_IN;
  wire saturating_packed_retired = SAT_RETIRE_IN;
  // level, so a retried stalled cycle counts again
  wire reorder_read_port_stall = ROB_PORT_STALL_IN;

  // ----------------------------------------
  // event select decode
  // ----------------------------------------
  reg hit;
  reg precise;
  always @* begin
    hit = 1'b0;
    precise = 1'b0;
    case (EVENT_SEL_IN)
      `PESD_EV_MEM_LOAD: begin
        precise = 1'b1;
        if (UNIT_MASK_IN == `PESD_UM_L2_LINE)
          hit = retired_load_l2_line_fetch;
        else if (UNIT_MASK_IN == `PESD_UM_XLATE)
          hit = retired_load_xlate_miss;
        else
          precise = 1'b0;
      end
      `PESD_EV_TRANS: begin
        if (UNIT_MASK_IN == `PESD_UM_TO_PINT)
          hit = float_to_packed_int_switch;
        else if (UNIT_MASK_IN == `PESD_UM_TO_FLOAT)
          hit = packed_int_to_float_switch;
      end
      `PESD_EV_ASSIST:
        hit = (UNIT_MASK_IN == `PESD_UM_NONE) & multimedia_assist;
      `PESD_EV_PINT_RET:
        hit = (UNIT_MASK_IN == `PESD_UM_NONE) & packed_int_retired;
      `PESD_EV_SAT_RET:
        hit = (UNIT_MASK_IN == `PESD_UM_NONE) & saturating_packed_retired;
      `PESD_EV_RAT_STALL:
        hit = (UNIT_MASK_IN == `PESD_UM_ROB_PORT) & reorder_read_port_stall;
      default:
        hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      COUNT_INC_OUT    <= 1'b0;
      SAMPLE_VALID_OUT <= 1'b0;
      SAMPLE_ADDR_OUT  <= `PESD_ADDR_RESET;
    end else begin
      COUNT_INC_OUT    <= hit;
      SAMPLE_VALID_OUT <= hit & precise;
      if (hit & precise)
        SAMPLE_ADDR_OUT <= NEXT_INSTR_ADDR_IN;
    end
  end

endmodule // pesd_top
`default_nettype wire

// [pesd_props.sv]
// checker on the counter pulse and sample address
`timescale 1ns/100ps
`default_nettype none
module pesd_props (input wire logic CLK_IN, RESETN_IN, COUNT_INC_OUT, LOAD_FAULT_IN,
  LOAD_LINE_IN_FLIGHT_IN, PINT_RETIRE_IN, SAT_RETIRE_IN, ROB_PORT_STALL_IN, SAMPLE_VALID_OUT,
  input wire logic [7:0] EVENT_SEL_IN, UNIT_MASK_IN,
  input wire logic [31:0] NEXT_INSTR_ADDR_IN, SAMPLE_ADDR_OUT);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  wire logic [15:0] em = {EVENT_SEL_IN, UNIT_MASK_IN};
  in_flight_a: assert property (em == 16'hcb08 && LOAD_LINE_IN_FLIGHT_IN |=> !COUNT_INC_OUT)
    else $error("line fetch counted twice");
  xlate_fault_a: assert property (em == 16'hcb10 && LOAD_FAULT_IN |=> !COUNT_INC_OUT)
    else $error("faulting load counted");
  sample_addr_a: assert property (COUNT_INC_OUT && $past(EVENT_SEL_IN) == 8'hcb |->
    SAMPLE_ADDR_OUT == $past(NEXT_INSTR_ADDR_IN)) else $error("sample address wrong");
  pint_count_a: assert property (em == 16'hce00 |=> COUNT_INC_OUT == $past(PINT_RETIRE_IN))
    else $error("packed retire count wrong");
  sat_count_a: assert property (em == 16'hcf00 |=> COUNT_INC_OUT == $past(SAT_RETIRE_IN))
    else $error("saturating count wrong");
  stall_cycle_a: assert property (em == 16'hd201 |=> COUNT_INC_OUT == $past(ROB_PORT_STALL_IN))
    else $error("stall cycle count wrong");
  mask_match_a: assert property (em == 16'hd202 |=> !COUNT_INC_OUT)
    else $error("wrong mask counted");
  no_event_a: assert property (em == 16'h0000 |=> !COUNT_INC_OUT)
    else $error("unselected event counted");
  sample_valid_a: assert property (SAMPLE_VALID_OUT |->
    COUNT_INC_OUT && $past(EVENT_SEL_IN) == 8'hcb) else $error("stray precise sample");
endmodule // pesd_props
bind pesd_top pesd_props i_pesd_props (.*);
`default_nettype wire

// [pesd_pipe.sv]
// pipeline stand-in that raises occurrence reports
`timescale 1ns/100ps
`default_nettype none
module pesd_pipe (input wire logic clk_in, output var logic [14:0] ev_out = 0,
  output var logic [31:0] addr_out = 0);
  // released address flips so a stale value never passes for a fresh sample
  task automatic send(input logic [14:0] v, input int n);
    ev_out <= v;
    addr_out <= 32'hc0de_0040;
    repeat (n) @(posedge clk_in);
    ev_out <= 0;
    addr_out <= 32'h3f21_ffbf;
  endtask
endmodule // pesd_pipe
`default_nettype wire

// [pesd_top_test.sv]
// self-checking bench for the event qualification block
`timescale 1ns/100ps
`default_nettype none
module pesd_top_test;
  logic clk = 0, rst_n = 0;
  logic [7:0] sel = 0, msk = 0;
  wire logic [14:0] ev;
  wire logic [31:0] na, sa;
  wire logic inc, sv;
  int err_total = 0, n_compared = 0, cnt = 0, vcnt = 0;
  pesd_pipe i_pesd_pipe (.clk_in(clk), .ev_out(ev), .addr_out(na));
  pesd_top i_pesd_top (.CLK_IN(clk), .RESETN_IN(rst_n), .EVENT_SEL_IN(sel), .UNIT_MASK_IN(msk),
    .LOAD_RETIRE_IN(ev[0]), .LOAD_CACHEABLE_IN(ev[1]), .LOAD_SW_PREFETCH_IN(ev[2]),
    .LOAD_BLOCKED_IN(ev[3]), .LOAD_FAULT_IN(ev[4]), .LOAD_L2_MISS_IN(ev[5]),
    .LOAD_LINE_IN_FLIGHT_IN(ev[6]), .LOAD_XLATE_MISS_IN(ev[7]), .NEXT_INSTR_ADDR_IN(na),
    .FLOAT_INSTR_IN(ev[8]), .PINT_INSTR_IN(ev[9]), .STATE_CLEAR_EXEC_IN(ev[10]),
    .STATE_CLEAR_ALTERS_IN(ev[11]), .PINT_RETIRE_IN(ev[12]), .SAT_RETIRE_IN(ev[13]),
    .ROB_PORT_STALL_IN(ev[14]), .COUNT_INC_OUT(inc), .SAMPLE_VALID_OUT(sv), .SAMPLE_ADDR_OUT(sa));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (inc === 1'b1) cnt <= cnt + 1;
  // precise samples exist only for the retired-load events
  always @(posedge clk) if (sv === 1'b1) vcnt <= vcnt + 1;
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  // select, hold the reports n cycles, then count the pulses
  task automatic run(input logic [15:0] em, input logic [14:0] v, input int n, exp);
    @(posedge clk);
    {sel, msk} <= em;
    cnt = 0;
    vcnt = 0;
    i_pesd_pipe.send(v, n);
    repeat (2) @(posedge clk);
    #1 chk(cnt, exp);
    chk(vcnt, (em[15:8] == 8'hcb) ? exp : 0);
  endtask
  task automatic loads;
    run(16'hcb08, 15'h0023, 3, 3);
    chk(sa, 32'hc0de_0040);
    run(16'hcb08, 15'h0063, 1, 0);
    run(16'hcb08, 15'h0027, 1, 0);
    run(16'hcb08, 15'h0021, 1, 0);
    run(16'hcb08, 15'h002b, 1, 0);
    run(16'hcb10, 15'h0083, 1, 1);
    run(16'hcb10, 15'h0093, 1, 0);
    $display("load events done");
  endtask
  task automatic others;
    run(16'hcc01, 15'h0200, 2, 1);
    run(16'hcc02, 15'h0100, 2, 1);
    run(16'hcd00, 15'h0c00, 1, 1);
    run(16'hcd00, 15'h0400, 1, 0);
    run(16'hce00, 15'h1000, 4, 4);
    run(16'hcf00, 15'h2000, 2, 2);
    run(16'hd201, 15'h4000, 5, 5);
    run(16'hd202, 15'h4000, 2, 0);
    run(16'h0000, 15'h7fff, 2, 0);
    $display("other events done");
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // the tests need some 90 cycles; 2000 leaves ample margin
  initial begin
    #100000;
    err_total++;
    end_of_test;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    loads;
    others;
    end_of_test;
  end
endmodule // pesd_top_test
`default_nettype wire
